// ==== hw/isvu_pkg.sv ====
// Shared constants and types for the interrupt source and vector unit
package isvu_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SRC = 12;
  localparam int NUM_FLAG = 13;
  localparam int NUM_LVL = 4;
  localparam int ADDR_W = 16;

  // ****************************************
  // Source index, in arbitration rank order
  // ****************************************
  localparam int SRC_EXT0 = 0;
  localparam int SRC_BROWNOUT = 1;
  localparam int SRC_WATCHDOG = 2;
  localparam int SRC_TIMER0 = 3;
  localparam int SRC_TWOWIRE = 4;
  localparam int SRC_EXT1 = 5;
  localparam int SRC_KEYBOARD = 6;
  localparam int SRC_CMP1 = 7;
  localparam int SRC_TIMER1 = 8;
  localparam int SRC_CMP2 = 9;
  localparam int SRC_SERIAL = 10;
  localparam int SRC_PWM = 11;

  // ****************************************
  // Flag index; the serial source owns two flags
  // ****************************************
  localparam int FLG_EXT0 = 0;
  localparam int FLG_BROWNOUT = 1;
  localparam int FLG_WATCHDOG = 2;
  localparam int FLG_TIMER0 = 3;
  localparam int FLG_TWOWIRE = 4;
  localparam int FLG_EXT1 = 5;
  localparam int FLG_KEYBOARD = 6;
  localparam int FLG_CMP1 = 7;
  localparam int FLG_TIMER1 = 8;
  localparam int FLG_CMP2 = 9;
  localparam int FLG_SER_RX = 10;
  localparam int FLG_PWM = 11;
  localparam int FLG_SER_TX = 12;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_FLAG = 1'b0;
  localparam logic [NUM_LVL-1:0] RST_IN_SERVICE = 4'h0;
  localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;

  // ****************************************
  // Vector table, indexed by source
  // ****************************************
  localparam logic [ADDR_W-1:0] VECTOR [NUM_SRC] = '{
    16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033, 16'h0013,
    16'h003b, 16'h0063, 16'h001b, 16'h0043, 16'h0023, 16'h0073
  };

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_LOAD = 2'b11,
    ST_POP = 2'b10
  } isvu_state_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [ADDR_W-1:0] wdata;
  } isvu_stack_t;

  typedef struct packed {
    logic load;
    logic [ADDR_W-1:0] addr;
  } isvu_pc_t;

endpackage

// ==== hw/isvu_flag.sv ====
// One interrupt flag cell with hardware set, hardware clear and software write
`timescale 1ns/1ns
module isvu_flag (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic hw_clr_i,
  input wire logic sw_we_i,
  input wire logic sw_d_i,
  output logic q_o
);

  logic next_q;

  // ****************************************
  // Next value
  // ****************************************
  // Set beats any clear so a coincident event is never lost
  always_comb begin
    if (set_i) begin
      next_q = 1'b1;
    end else if (sw_we_i) begin
      next_q = sw_d_i;
    end else begin
      next_q = q_o & ~hw_clr_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= isvu_pkg::RST_FLAG;
    end else begin
      q_o <= next_q;
    end
  end

endmodule

// ==== hw/isvu_top.sv ====
// Interrupt source gathering, arbitration and vector call sequencing
//
// Summary of operation
// - Per-pin trigger bit picks edge or level
// - Edge mode: high then low sample sets flag
// - Edge flag cleared on vectoring
// - Level flag not cleared; low pin re-requests
// - Timer overflows set flags, cleared on vectoring
// - Watchdog timeout sets flag, software clears
// - Serial rx/tx flags share request, software clears
// - Software may set or clear every flag
// - Per-source enables plus global enable
// - Comparator toggle sets flag, software clears
// - New two-wire status sets flag, software clears
// - Active brake sets flag, software clears
// - Sample and arbitrate every machine cycle
// - Call needs level, last cycle, no blocking insn
// - Denied requests are not remembered
// - Call pushes PC, not status, loads vector
// - Vectors for ext0, timers, ext1, serial, brownout
// - Vectors for two-wire, keyboard, comparators, watchdog, PWM
// - Return pops stack top into PC
// - Only interrupt return ends in-service level
// - Two priority bits per source, level 3 highest
// - Preempt only by strictly higher level
// - Fixed rank breaks equal-level ties
`timescale 1ns/1ns
module isvu_top (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic MCYCLE_I,
  input wire logic EXT_IRQ0_PIN_I,
  input wire logic EXT_IRQ1_PIN_I,
  input wire logic EXT0_TRIGGER_TYPE_I,
  input wire logic EXT1_TRIGGER_TYPE_I,
  input wire logic TIMER0_OVERFLOW_I,
  input wire logic TIMER1_OVERFLOW_I,
  input wire logic WATCHDOG_TIMEOUT_I,
  input wire logic SERIAL_RX_DONE_I,
  input wire logic SERIAL_TX_DONE_I,
  input wire logic COMPARATOR1_OUT_I,
  input wire logic COMPARATOR2_OUT_I,
  input wire logic TWOWIRE_STATUS_NEW_I,
  input wire logic KEYBOARD_EVENT_I,
  input wire logic BROWNOUT_EVENT_I,
  input wire logic PWM_BRAKE_I,
  input wire logic [isvu_pkg::NUM_FLAG-1:0] FLAG_WE_I,
  input wire logic [isvu_pkg::NUM_FLAG-1:0] FLAG_WDATA_I,
  input wire logic [isvu_pkg::NUM_SRC-1:0] IRQ_ENABLE_I,
  input wire logic GLOBAL_IRQ_ENABLE_I,
  input wire logic [isvu_pkg::NUM_SRC-1:0] PRIORITY_HIGH_I,
  input wire logic [isvu_pkg::NUM_SRC-1:0] PRIORITY_LOW_I,
  input wire logic LAST_CYCLE_I,
  input wire logic BLOCKING_WRITE_I,
  input wire logic RETURN_FROM_INTERRUPT_I,
  input wire logic RETURN_PLAIN_I,
  input wire logic [isvu_pkg::ADDR_W-1:0] PC_I,
  input wire logic [isvu_pkg::ADDR_W-1:0] STACK_RDATA_I,
  output logic [isvu_pkg::NUM_FLAG-1:0] FLAGS_O,
  output logic [isvu_pkg::NUM_LVL-1:0] IN_SERVICE_O,
  output isvu_pkg::isvu_stack_t STACK_O,
  output isvu_pkg::isvu_pc_t PC_LOAD_O,
  output logic BUSY_O
);

  // ****************************************
  // Declarations
  // ****************************************
  logic ext0_sample;
  logic ext1_sample;
  logic cmp1_prev;
  logic cmp2_prev;
  logic [isvu_pkg::NUM_FLAG-1:0] flag_set;
  logic [isvu_pkg::NUM_FLAG-1:0] flag_hw_clr;
  logic [isvu_pkg::NUM_FLAG-1:0] flag_q;
  logic [isvu_pkg::NUM_SRC-1:0] src_flag;
  logic [isvu_pkg::NUM_SRC-1:0] src_pending;
  logic [1:0] src_level [isvu_pkg::NUM_SRC];
  logic best_found;
  logic [3:0] best_src;
  logic [1:0] best_level;
  logic [isvu_pkg::NUM_LVL-1:0] in_service;
  logic [isvu_pkg::NUM_LVL-1:0] next_in_service;
  logic any_active;
  logic [1:0] cur_level;
  logic accept;
  logic call_window;
  logic level_clear;
  logic do_return;
  logic [isvu_pkg::ADDR_W-1:0] saved_pc;
  logic [isvu_pkg::ADDR_W-1:0] load_addr;
  isvu_pkg::isvu_state_t state;
  isvu_pkg::isvu_state_t next_state;

  // ****************************************
  // External pin sampling
  // ****************************************
  // One sample per machine cycle; pulses shorter than that may be missed
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ext0_sample <= 1'b1;
      ext1_sample <= 1'b1;
    end else if (MCYCLE_I) begin
      ext0_sample <= EXT_IRQ0_PIN_I;
      ext1_sample <= EXT_IRQ1_PIN_I;
    end
  end

  // ****************************************
  // Comparator toggle detection
  // ****************************************
  // Reset low; a comparator already high flags one toggle after reset
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cmp1_prev <= 1'b0;
      cmp2_prev <= 1'b0;
    end else begin
      cmp1_prev <= COMPARATOR1_OUT_I;
      cmp2_prev <= COMPARATOR2_OUT_I;
    end
  end

  // ****************************************
  // Flag set and hardware clear terms
  // ****************************************
  always_comb begin
    flag_set = '0;
    // Edge: high sample followed by low sample; level: low sample keeps it set
    if (EXT0_TRIGGER_TYPE_I) begin
      flag_set[isvu_pkg::FLG_EXT0] = MCYCLE_I & ext0_sample & ~EXT_IRQ0_PIN_I;
    end else begin
      flag_set[isvu_pkg::FLG_EXT0] = MCYCLE_I & ~EXT_IRQ0_PIN_I;
    end
    if (EXT1_TRIGGER_TYPE_I) begin
      flag_set[isvu_pkg::FLG_EXT1] = MCYCLE_I & ext1_sample & ~EXT_IRQ1_PIN_I;
    end else begin
      flag_set[isvu_pkg::FLG_EXT1] = MCYCLE_I & ~EXT_IRQ1_PIN_I;
    end
    flag_set[isvu_pkg::FLG_TIMER0] = TIMER0_OVERFLOW_I;
    flag_set[isvu_pkg::FLG_TIMER1] = TIMER1_OVERFLOW_I;
    flag_set[isvu_pkg::FLG_WATCHDOG] = WATCHDOG_TIMEOUT_I;
    flag_set[isvu_pkg::FLG_SER_RX] = SERIAL_RX_DONE_I;
    flag_set[isvu_pkg::FLG_SER_TX] = SERIAL_TX_DONE_I;
    flag_set[isvu_pkg::FLG_CMP1] = COMPARATOR1_OUT_I ^ cmp1_prev;
    flag_set[isvu_pkg::FLG_CMP2] = COMPARATOR2_OUT_I ^ cmp2_prev;
    flag_set[isvu_pkg::FLG_TWOWIRE] = TWOWIRE_STATUS_NEW_I;
    flag_set[isvu_pkg::FLG_KEYBOARD] = KEYBOARD_EVENT_I;
    flag_set[isvu_pkg::FLG_BROWNOUT] = BROWNOUT_EVENT_I;
    flag_set[isvu_pkg::FLG_PWM] = PWM_BRAKE_I;
  end

  // Only edge external flags and timer flags are cleared by the call itself
  always_comb begin
    flag_hw_clr = '0;
    if (accept) begin
      if (best_src == 4'(isvu_pkg::SRC_EXT0)) begin
        flag_hw_clr[isvu_pkg::FLG_EXT0] = EXT0_TRIGGER_TYPE_I;
      end
      if (best_src == 4'(isvu_pkg::SRC_EXT1)) begin
        flag_hw_clr[isvu_pkg::FLG_EXT1] = EXT1_TRIGGER_TYPE_I;
      end
      if (best_src == 4'(isvu_pkg::SRC_TIMER0)) begin
        flag_hw_clr[isvu_pkg::FLG_TIMER0] = 1'b1;
      end
      if (best_src == 4'(isvu_pkg::SRC_TIMER1)) begin
        flag_hw_clr[isvu_pkg::FLG_TIMER1] = 1'b1;
      end
    end
  end

  // ****************************************
  // Flag cells
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < isvu_pkg::NUM_FLAG; gi++) begin : g_flag
      isvu_flag u_flag (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .set_i(flag_set[gi]),
        .hw_clr_i(flag_hw_clr[gi]),
        .sw_we_i(FLAG_WE_I[gi]),
        .sw_d_i(FLAG_WDATA_I[gi]),
        .q_o(flag_q[gi])
      );
    end
  endgenerate

  assign FLAGS_O = flag_q;

  // ****************************************
  // Source requests
  // ****************************************
  always_comb begin
    src_flag = flag_q[isvu_pkg::NUM_SRC-1:0];
    src_flag[isvu_pkg::SRC_SERIAL] = flag_q[isvu_pkg::FLG_SER_RX] |
                                     flag_q[isvu_pkg::FLG_SER_TX];
  end

  assign src_pending = src_flag & IRQ_ENABLE_I & {isvu_pkg::NUM_SRC{GLOBAL_IRQ_ENABLE_I}};

  always_comb begin
    for (int i = 0; i < isvu_pkg::NUM_SRC; i++) begin
      src_level[i] = {PRIORITY_HIGH_I[i], PRIORITY_LOW_I[i]};
    end
  end

  // ****************************************
  // Arbitration
  // ****************************************
  // Scan from lowest rank up; a later winner needs an equal or higher level,
  // so the best-ranked source wins among equals
  always_comb begin
    best_found = 1'b0;
    best_src = 4'h0;
    best_level = 2'h0;
    for (int i = isvu_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (src_pending[i] && (!best_found || src_level[i] >= best_level)) begin
        best_found = 1'b1;
        best_src = 4'(i);
        best_level = src_level[i];
      end
    end
  end

  // Highest level currently in service
  always_comb begin
    any_active = |in_service;
    cur_level = 2'h0;
    for (int l = 0; l < isvu_pkg::NUM_LVL; l++) begin
      if (in_service[l]) begin
        cur_level = 2'(l);
      end
    end
  end

  // Instruction boundary with no enable, priority or interrupt return in flight
  assign call_window = MCYCLE_I & LAST_CYCLE_I
                       & ~BLOCKING_WRITE_I & ~RETURN_FROM_INTERRUPT_I;

  // Equal level never preempts, so level 3 is never interrupted
  assign level_clear = ~any_active | (best_level > cur_level);

  // Decision taken fresh each machine cycle from live flags; nothing is held
  assign accept = call_window & best_found & (state == isvu_pkg::ST_IDLE)
                  & level_clear;

  assign do_return = (state == isvu_pkg::ST_IDLE) & ~accept &
                     (RETURN_FROM_INTERRUPT_I | RETURN_PLAIN_I);

  // ****************************************
  // In-service record
  // ****************************************
  // A plain return pops the stack but keeps the level marked
  always_comb begin
    next_in_service = in_service;
    if (accept) begin
      next_in_service[best_level] = 1'b1;
    end else if (do_return && RETURN_FROM_INTERRUPT_I) begin
      next_in_service[cur_level] = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      in_service <= isvu_pkg::RST_IN_SERVICE;
    end else begin
      in_service <= next_in_service;
    end
  end

  assign IN_SERVICE_O = in_service;

  // ****************************************
  // Call and return sequencer
  // ****************************************
  // Return pulses while busy are dropped; the core must not send them
  always_comb begin
    next_state = state;
    unique case (state)
      isvu_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = isvu_pkg::ST_PUSH;
        end else if (do_return) begin
          next_state = isvu_pkg::ST_POP;
        end
      end
      isvu_pkg::ST_PUSH: begin
        next_state = isvu_pkg::ST_LOAD;
      end
      isvu_pkg::ST_POP: begin
        next_state = isvu_pkg::ST_LOAD;
      end
      isvu_pkg::ST_LOAD: begin
        next_state = isvu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= isvu_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Return address captured at acceptance; status word is left alone
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      saved_pc <= isvu_pkg::RST_ADDR;
    end else if (accept) begin
      saved_pc <= PC_I;
    end
  end

  // Target: vector on a call, whatever the stack holds on a return
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      load_addr <= isvu_pkg::RST_ADDR;
    end else if (accept) begin
      load_addr <= isvu_pkg::VECTOR[best_src];
    end else if (state == isvu_pkg::ST_POP) begin
      load_addr <= STACK_RDATA_I;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    STACK_O.push = (state == isvu_pkg::ST_PUSH);
    STACK_O.pop = (state == isvu_pkg::ST_POP);
    STACK_O.wdata = saved_pc;
    PC_LOAD_O.load = (state == isvu_pkg::ST_LOAD);
    PC_LOAD_O.addr = load_addr;
  end

  assign BUSY_O = (state != isvu_pkg::ST_IDLE);

endmodule

// ==== tb/isvu_properties.sv ====
// Port-level checks for the vector unit
`timescale 1ns/1ns
module isvu_properties (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic MCYCLE_I,
  input wire logic LAST_CYCLE_I,
  input wire logic BLOCKING_WRITE_I,
  input wire logic RETURN_FROM_INTERRUPT_I,
  input wire logic RETURN_PLAIN_I,
  input wire logic GLOBAL_IRQ_ENABLE_I,
  input wire logic TIMER0_OVERFLOW_I,
  input wire logic [15:0] PC_I,
  input wire logic [15:0] STACK_RDATA_I,
  input wire logic [12:0] FLAGS_O,
  input wire logic [3:0] IN_SERVICE_O,
  input wire isvu_pkg::isvu_stack_t STACK_O,
  input wire isvu_pkg::isvu_pc_t PC_LOAD_O
);
  // ****************************************
  // Call gate and sequencing
  // ****************************************
  logic gate;
  assign gate = MCYCLE_I & LAST_CYCLE_I & ~BLOCKING_WRITE_I & ~RETURN_FROM_INTERRUPT_I
    & GLOBAL_IRQ_ENABLE_I;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_call_gate: assert property (STACK_O.push |-> $past(gate))
    else $error("call outside gate");
  a_push_pc: assert property (STACK_O.push |-> STACK_O.wdata == $past(PC_I))
    else $error("pushed value not pc");
  a_load_vector: assert property (STACK_O.push |=> PC_LOAD_O.load && PC_LOAD_O.addr[2:0] == 3'h3)
    else $error("no vector load");
  a_pop_load: assert property (STACK_O.pop |=> PC_LOAD_O.load && PC_LOAD_O.addr == $past(STACK_RDATA_I))
    else $error("pop not loaded");
  a_return_from_interrupt_ends: assert property (STACK_O.pop && $past(RETURN_FROM_INTERRUPT_I) && $past(IN_SERVICE_O) != 4'h0 |-> IN_SERVICE_O < $past(IN_SERVICE_O))
    else $error("level kept after return");
  a_ret_keeps: assert property (STACK_O.pop && $past(RETURN_PLAIN_I) |-> $stable(IN_SERVICE_O))
    else $error("plain return ended level");
  a_nest_up: assert property (STACK_O.push |-> IN_SERVICE_O > $past(IN_SERVICE_O))
    else $error("call not above level");
  a_timer_set: assert property (TIMER0_OVERFLOW_I |=> FLAGS_O[isvu_pkg::FLG_TIMER0])
    else $error("overflow flag not set");
endmodule

// ==== tb/isvu_cpu_model.sv ====
// Behavioural sequencer: machine-cycle strobe and return stack
`timescale 1ns/1ns
module isvu_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire isvu_pkg::isvu_stack_t stack_i,
  output logic mcycle_o,
  output logic [15:0] rdata_o
);
  // ****************************************
  // Strobe and stack
  // ****************************************
  logic [1:0] phase;
  logic [3:0] sp;
  logic [15:0] mem [16];
  logic [15:0] top;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign mcycle_o = (phase == 2'h3);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sp <= 4'h0;
    end else if (stack_i.push) begin
      mem[sp] <= stack_i.wdata;
      sp <= sp + 4'h1;
    end else if (stack_i.pop && sp != 4'h0) begin
      sp <= sp - 4'h1;
    end
  end
  // Empty stack reads zero; stale top is inverted so a late read shows
  assign top = (sp == 4'h0) ? 16'h0000 : mem[sp - 4'h1];
  assign rdata_o = stack_i.pop ? top : ~top;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the vector unit
`timescale 1ns/1ns
module tb;
  localparam logic [15:0] VT [12] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033,
    16'h0013, 16'h003b, 16'h0063, 16'h001b, 16'h0043, 16'h0023, 16'h0073};
  logic MCLK_I = '0, SYS_RST_I = '1, MCYCLE_I, BUSY_O;
  logic EXT_IRQ0_PIN_I = '1, EXT_IRQ1_PIN_I = '1, EXT0_TRIGGER_TYPE_I = '1;
  logic EXT1_TRIGGER_TYPE_I = '1, TIMER0_OVERFLOW_I = '0, TIMER1_OVERFLOW_I = '0;
  logic WATCHDOG_TIMEOUT_I = '0, SERIAL_RX_DONE_I = '0, SERIAL_TX_DONE_I = '0;
  logic COMPARATOR1_OUT_I = '0, COMPARATOR2_OUT_I = '0, TWOWIRE_STATUS_NEW_I = '0;
  logic KEYBOARD_EVENT_I = '0, BROWNOUT_EVENT_I = '0, PWM_BRAKE_I = '0;
  logic GLOBAL_IRQ_ENABLE_I = '0, LAST_CYCLE_I = '0, BLOCKING_WRITE_I = '0;
  logic RETURN_FROM_INTERRUPT_I = '0, RETURN_PLAIN_I = '0;
  logic [12:0] FLAG_WE_I = '0, FLAG_WDATA_I = '0, FLAGS_O;
  logic [11:0] IRQ_ENABLE_I = '0, PRIORITY_HIGH_I = '0, PRIORITY_LOW_I = '0;
  logic [15:0] PC_I = '0, STACK_RDATA_I;
  logic [3:0] IN_SERVICE_O;
  isvu_pkg::isvu_stack_t STACK_O;
  isvu_pkg::isvu_pc_t PC_LOAD_O;
  int seed = 54, bad_count = 0, cmp_count = 0;
  isvu_top dut_u (.MCLK_I, .SYS_RST_I, .MCYCLE_I, .EXT_IRQ0_PIN_I, .EXT_IRQ1_PIN_I,
    .EXT0_TRIGGER_TYPE_I, .EXT1_TRIGGER_TYPE_I, .TIMER0_OVERFLOW_I, .TIMER1_OVERFLOW_I,
    .WATCHDOG_TIMEOUT_I, .SERIAL_RX_DONE_I, .SERIAL_TX_DONE_I, .COMPARATOR1_OUT_I,
    .COMPARATOR2_OUT_I, .TWOWIRE_STATUS_NEW_I, .KEYBOARD_EVENT_I, .BROWNOUT_EVENT_I,
    .PWM_BRAKE_I, .FLAG_WE_I, .FLAG_WDATA_I, .IRQ_ENABLE_I, .GLOBAL_IRQ_ENABLE_I,
    .PRIORITY_HIGH_I, .PRIORITY_LOW_I, .LAST_CYCLE_I, .BLOCKING_WRITE_I,
    .RETURN_FROM_INTERRUPT_I, .RETURN_PLAIN_I, .PC_I, .STACK_RDATA_I, .FLAGS_O,
    .IN_SERVICE_O, .STACK_O, .PC_LOAD_O, .BUSY_O);
  isvu_cpu_model cpu_u (.clk_i(MCLK_I), .rst_i(SYS_RST_I), .stack_i(STACK_O),
    .mcycle_o(MCYCLE_I), .rdata_o(STACK_RDATA_I));
  initial forever #2 MCLK_I = ~MCLK_I;
  // Random instruction ends and register writes delay calls
  always @(posedge MCLK_I) begin
    LAST_CYCLE_I <= 1'($random(seed));
    BLOCKING_WRITE_I <= 1'($random(seed));
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [12:0] we, input logic [12:0] d);
    FLAG_WE_I <= we;
    FLAG_WDATA_I <= d;
    @(posedge MCLK_I);
    FLAG_WE_I <= '0;
    repeat (2) @(posedge MCLK_I);
  endtask
  task automatic ckf(input logic [12:0] f, input logic [3:0] s);
    @(negedge MCLK_I);
    chk(16'(FLAGS_O), 16'(f));
    chk(16'(IN_SERVICE_O), 16'(s));
    @(posedge MCLK_I);
  endtask
  task automatic wload(input logic exp, output logic [15:0] a);
    logic got;
    logic busy;
    got = '0;
    busy = '0;
    a = '0;
    for (int i = 0; i < 200 && got !== 1'b1; i++) begin
      @(negedge MCLK_I);
      got = PC_LOAD_O.load;
      busy = BUSY_O;
      a = PC_LOAD_O.addr;
    end
    @(posedge MCLK_I);
    chk(16'(got), 16'(exp));
    chk(16'(busy), 16'(exp));
    if (exp && got !== 1'b1) print_verdict();
  endtask
  task automatic ret(input logic intr, output logic [15:0] a);
    RETURN_FROM_INTERRUPT_I <= intr;
    RETURN_PLAIN_I <= ~intr;
    @(posedge MCLK_I);
    RETURN_FROM_INTERRUPT_I <= '0;
    RETURN_PLAIN_I <= '0;
    wload(1'b1, a);
  endtask
  // Best level wins, lower index breaks ties
  function automatic int win(input logic [11:0] p, input logic [11:0] h, input logic [11:0] l);
    int b;
    b = -1;
    for (int i = 11; i >= 0; i--) if (p[i] && (b < 0 || {h[i], l[i]} >= {h[b], l[b]})) b = i;
    return b;
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [11:0] m, p;
    logic [12:0] d;
    logic [12:0] e;
    logic [15:0] a;
    int w, lv, s;
    repeat (6) @(posedge MCLK_I);
    SYS_RST_I <= '0;
    @(posedge MCLK_I);
    ckf('0, '0);
    {TIMER0_OVERFLOW_I, TIMER1_OVERFLOW_I, WATCHDOG_TIMEOUT_I, SERIAL_RX_DONE_I} <= '1;
    {SERIAL_TX_DONE_I, TWOWIRE_STATUS_NEW_I, KEYBOARD_EVENT_I, BROWNOUT_EVENT_I} <= '1;
    {PWM_BRAKE_I, COMPARATOR1_OUT_I, COMPARATOR2_OUT_I} <= '1;
    @(posedge MCLK_I);
    {TIMER0_OVERFLOW_I, TIMER1_OVERFLOW_I, WATCHDOG_TIMEOUT_I, SERIAL_RX_DONE_I} <= '0;
    {SERIAL_TX_DONE_I, TWOWIRE_STATUS_NEW_I, KEYBOARD_EVENT_I, BROWNOUT_EVENT_I} <= '0;
    PWM_BRAKE_I <= '0;
    repeat (8) @(posedge MCLK_I);
    ckf(13'h1fde, '0);
    wr('1, '0);
    ckf('0, '0);
    wr('1, '1);
    ckf('1, '0);
    wr('1, '0);
    EXT_IRQ0_PIN_I <= '0;
    repeat (8) @(posedge MCLK_I);
    ckf(13'h0001, '0);
    EXT_IRQ0_PIN_I <= '1;
    EXT1_TRIGGER_TYPE_I <= '0;
    EXT_IRQ1_PIN_I <= '0;
    wr('1, '0);
    repeat (8) @(posedge MCLK_I);
    ckf(13'h0020, '0);
    IRQ_ENABLE_I <= 12'h020;
    GLOBAL_IRQ_ENABLE_I <= '1;
    wload(1'b1, a);
    chk(a, VT[5]);
    ckf(13'h0020, 4'h1);
    EXT_IRQ1_PIN_I <= '1;
    GLOBAL_IRQ_ENABLE_I <= '0;
    repeat (8) @(posedge MCLK_I);
    wr('1, '0);
    ret(1'b1, a);
    EXT1_TRIGGER_TYPE_I <= '1;
    IRQ_ENABLE_I <= '1;
    wr(13'h0008, 13'h0008);
    wr(13'h0008, '0);
    GLOBAL_IRQ_ENABLE_I <= '1;
    wload(1'b0, a);
    for (int n = 0; n < 30; n++) begin
      GLOBAL_IRQ_ENABLE_I <= '0;
      m = 12'($random(seed));
      EXT0_TRIGGER_TYPE_I <= n[1];
      d = {m[10] & n[0], m[11], m[10] & ~n[0], m[9:0]};
      PRIORITY_HIGH_I <= 12'($random(seed));
      PRIORITY_LOW_I <= 12'($random(seed));
      IRQ_ENABLE_I <= 12'($random(seed));
      PC_I <= 16'($random(seed));
      wr('1, d);
      p = m & IRQ_ENABLE_I;
      w = win(p, PRIORITY_HIGH_I, PRIORITY_LOW_I);
      GLOBAL_IRQ_ENABLE_I <= '1;
      wload(p != 0, a);
      if (p != 0) begin
        lv = {PRIORITY_HIGH_I[w], PRIORITY_LOW_I[w]};
        chk(a, VT[w]);
        e = d & ~13'((12'h128 | 12'(EXT0_TRIGGER_TYPE_I)) & (12'h1 << w));
        ckf(e, 4'(1 << lv));
        GLOBAL_IRQ_ENABLE_I <= '0;
        s = {$random(seed)} % 12;
        wr('1, 13'(13'h1 << s));
        GLOBAL_IRQ_ENABLE_I <= '1;
        wload(IRQ_ENABLE_I[s] && {PRIORITY_HIGH_I[s], PRIORITY_LOW_I[s]} > lv, a);
      end
      GLOBAL_IRQ_ENABLE_I <= '0;
      wr('1, '0);
      if (IN_SERVICE_O != 0) begin
        ret(~n[0], a);
        chk(a, PC_I);
        for (int k = 0; k < 3 && IN_SERVICE_O != 0; k++) ret(1'b1, a);
      end
      ckf('0, '0);
    end
    IRQ_ENABLE_I <= '1;
    wr(13'h0001, 13'h0001);
    GLOBAL_IRQ_ENABLE_I <= '1;
    wload(1'b1, a);
    SYS_RST_I <= '1;
    repeat (2) @(posedge MCLK_I);
    SYS_RST_I <= '0;
    GLOBAL_IRQ_ENABLE_I <= '0;
    ckf('0, '0);
    print_verdict();
  end
endmodule
bind isvu_top isvu_properties chk_u (.MCLK_I, .SYS_RST_I, .MCYCLE_I, .LAST_CYCLE_I,
  .BLOCKING_WRITE_I, .RETURN_FROM_INTERRUPT_I, .RETURN_PLAIN_I, .GLOBAL_IRQ_ENABLE_I,
  .TIMER0_OVERFLOW_I, .PC_I, .STACK_RDATA_I, .FLAGS_O, .IN_SERVICE_O, .STACK_O, .PC_LOAD_O);
